//--- csk_pkg.sv
// csk_pkg: register map, configuration word layout and codes shared by the
// key source selector and its key store.
// assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
package csk_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STAT   = 8'h04;
  localparam logic [7:0] OFF_OTP    = 8'h08;
  localparam logic [7:0] OFF_DLO    = 8'h0C;
  localparam logic [7:0] OFF_DHI    = 8'h10;
  localparam logic [7:0] OFF_IST    = 8'h14;
  localparam logic [7:0] OFF_IMSK   = 8'h18;
  localparam logic [7:0] OFF_CFG    = 8'h1C;
  localparam logic [7:0] OFF_SWK0   = 8'h20;
  localparam logic [7:0] OFF_SWK5   = 8'h34;

  // secure_config_word layout
  localparam int CFG_PROGRAMMED_BIT = 30;
  localparam int CFG_TYPE_LSB       = 20;
  localparam int CFG_SKEY_BIT       = 19;
  localparam int CFG_LKSRC_LSB      = 11;
  localparam int CFG_LOCK_BIT       = 10;
  localparam int CFG_PAGE_WRITE_LOCK_LSB     = 1;
  localparam int CFG_SWDIS_BIT      = 0;
  // reserved bit 31 and unimplemented bits 29-28 never program
  localparam logic [31:0] CFG_PROG_MASK = 32'h4FFF_FFFF;

  // control and OTP register fields
  localparam int CTRL_SRC_LSB  = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int OTP_CMD_BIT   = 0;
  localparam int OTP_PAGE_LSB  = 1;

  // key modes (DES cipher)
  localparam logic [1:0] MODE_DES1 = 2'h0;
  localparam logic [1:0] MODE_DES2 = 2'h1;
  localparam logic [1:0] MODE_RSVD = 2'h2;
  localparam logic [1:0] MODE_DES3 = 2'h3;

  // stored key page-pair types
  localparam logic [1:0] TYPE_DES12  = 2'h0;
  localparam logic [1:0] TYPE_DES3   = 2'h1;
  localparam logic [1:0] TYPE_AES128 = 2'h2;
  localparam logic [1:0] TYPE_AES256 = 2'h3;

  localparam logic [3:0] SRC_SW   = 4'h0;
  localparam logic [3:0] SRC_KEY1 = 4'h1;
  localparam logic [3:0] SRC_RSVD = 4'hF;

  localparam int          NUM_PAGES = 9;
  localparam logic [3:0]  LAST_PAGE = 4'h8;

  // interrupt event bits
  localparam int EV_PROG_DONE   = 0;
  localparam int EV_PROG_REFUSE = 1;
  localparam int EV_START_REFUSE = 2;
  localparam int EV_W            = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- csk_key_store.sv
// csk_key_store: program-once page store, page 0 is the configuration word,
// pages 1..8 each hold one 64-bit stored key.
// a program strobe for a page whose write lock bit is set is ignored here.
`timescale 1ns/1ps
module csk_key_store #(
  parameter int PAGES = csk_pkg::NUM_PAGES
) (
  input  wire logic        mclk,       // system clock
  input  wire logic        rst,        // synchronous reset, high
  input  wire logic        prog_en,    // one-cycle program strobe
  input  wire logic [3:0]  prog_page,  // page to program
  input  wire logic [63:0] prog_data,  // bits to program
  input  wire logic [2:0]  rd_slice,   // stored key slice to read
  output logic      [63:0] rd_data,    // registered key slice
  output logic      [31:0] cfg_word    // configuration word
);

  logic [PAGES-1:0][63:0] page_q;
  logic [PAGES-1:0][63:0] page_d;

  if (PAGES != csk_pkg::NUM_PAGES) begin : g_bad_pages
    $error("csk_key_store: PAGES must be 9");
  end

  // bits only ever go from blank to programmed; a blank bit in the data
  // leaves a programmed bit alone, so nothing is reprogrammed
  for (genvar p = 0; p < PAGES; p++) begin : g_page
    logic locked;
    assign locked = page_q[0][csk_pkg::CFG_PAGE_WRITE_LOCK_LSB + p];
    always_comb begin
      page_d[p] = page_q[p];
      if (prog_en && prog_page == 4'(p) && !locked) begin
        if (p == 0) begin
          page_d[p] = page_q[p]
                    | {32'h0, prog_data[31:0] & csk_pkg::CFG_PROG_MASK};
        end else begin
          page_d[p] = page_q[p] | prog_data;
        end
      end
    end
  end

  // the array stands in for fuses; a reset clears it only so simulation
  // starts from a blank part
  always_ff @(posedge mclk) begin
    if (rst) begin
      page_q  <= '0;
      rd_data <= 64'h0;
    end else begin
      page_q  <= page_d;
      rd_data <= page_q[rd_slice + 3'h1 == 3'h0 ? 4'h8 : {1'b0, rd_slice + 3'h1}];
    end
  end

  assign cfg_word = page_q[0][31:0];

endmodule

//--- csk_key_select.sv
// csk_key_select: key source selection and secure configuration for the
// DES/3DES key path, with an AXI4-Lite register slave and interrupt.
// assumes a cipher datapath that asks for each pass key and starts
// operations through op_start_req; single clock, synchronous reset.
`timescale 1ns/1ps
module csk_key_select #(
  parameter int KEY_SLICES = 8
) (
  input  wire logic        mclk,              // system clock, 20 MHz
  input  wire logic        rst,               // synchronous reset, high
  input  wire logic        s_axi_awvalid,     // write address valid
  output logic             s_axi_awready,     // write address ready
  input  wire logic [7:0]  s_axi_awaddr,      // write byte address
  input  wire logic        s_axi_wvalid,      // write data valid
  output logic             s_axi_wready,      // write data ready
  input  wire logic [31:0] s_axi_wdata,       // write data
  input  wire logic [3:0]  s_axi_wstrb,       // byte enables
  output logic             s_axi_bvalid,      // write response valid
  input  wire logic        s_axi_bready,      // write response ready
  output logic      [1:0]  s_axi_bresp,       // write response
  input  wire logic        s_axi_arvalid,     // read address valid
  output logic             s_axi_arready,     // read address ready
  input  wire logic [7:0]  s_axi_araddr,      // read byte address
  output logic             s_axi_rvalid,      // read data valid
  input  wire logic        s_axi_rready,      // read data ready
  output logic      [31:0] s_axi_rdata,       // read data
  output logic      [1:0]  s_axi_rresp,       // read response
  input  wire logic        op_start_req,      // cipher asks to start
  output logic             op_start_ok,       // start granted
  input  wire logic [1:0]  key_pass,          // pass 0,1,2 of the cipher
  output logic      [63:0] key_data,          // key for that pass, 1 late
  output logic      [3:0]  eff_source,        // effective key source
  output logic             key_config_fail,   // live key failure flag
  output logic             program_test_mirror, // configured-page flag
  output logic             irq                // level interrupt
);

  typedef struct packed {
    logic              aw_full;
    logic [7:0]        aw_addr;
    logic              w_full;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [1:0]        mode;
    logic [3:0]        src;
    logic              otp_cmd;
    logic [3:0]        page;
    logic [31:0]       dlo;
    logic [31:0]       dhi;
    logic [5:0][31:0]  swk;
    logic [2:0]        ist;
    logic [2:0]        imask;
    logic              use_sw;
    logic [63:0]       sw_slice;
  } csk_state_s;

  csk_state_s s_q;
  csk_state_s s_d;

  logic [31:0] cfg;
  logic [63:0] mem_rd;
  logic [2:0]  sl1;
  logic [2:0]  sl2;
  logic [2:0]  sl3;
  logic [2:0]  sel_sl;
  logic        use_sw;
  logic        bad;
  logic [3:0]  lk_src;
  logic [7:0]  lk;
  logic        wr_go;
  logic [csk_pkg::EV_W-1:0] ev;

  if (KEY_SLICES != 8) begin : g_bad_slices
    $error("csk_key_select: KEY_SLICES must be 8");
  end

  csk_key_store u_store (
    .mclk      (mclk),
    .rst       (rst),
    .prog_en   (s_q.otp_cmd),
    .prog_page (s_q.page),
    .prog_data ({s_q.dhi, s_q.dlo}),
    .rd_slice  (sel_sl),
    .rd_data   (mem_rd),
    .cfg_word  (cfg)
  );

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] type_of(input logic [31:0] c,
                                         input logic [2:0]  k);
    // slice k sits in page k+1; pages pair up as (1,2),(3,4),...
    return c[csk_pkg::CFG_TYPE_LSB + 2 * int'(k[2:1]) +: 2];
  endfunction

  function automatic logic page_fail(input logic [31:0] c,
                                     input logic [3:0]  p);
    logic r;
    r = 1'b1;
    if (p <= csk_pkg::LAST_PAGE) begin
      r = c[csk_pkg::CFG_PAGE_WRITE_LOCK_LSB + int'(p)];
    end
    return r;
  endfunction

  // key source decoder, purely combinational
  always_comb begin
    lk     = cfg[csk_pkg::CFG_LKSRC_LSB +: 8];
    lk_src = csk_pkg::SRC_SW;
    for (int i = 0; i < 7; i++) begin
      if (lk[i]) begin
        lk_src = 4'(i + 1);
      end
    end
    if (lk[7]) begin
      lk_src = csk_pkg::SRC_RSVD;
    end
    if (cfg[csk_pkg::CFG_LOCK_BIT]) begin
      eff_source = lk_src;
    end else begin
      eff_source = s_q.src;
    end
    bad    = 1'b0;
    use_sw = 1'b0;
    sl1    = 3'h0;
    sl2    = 3'h0;
    sl3    = 3'h0;
    case (s_q.mode)
      csk_pkg::MODE_DES1: begin
        if (eff_source == csk_pkg::SRC_SW) begin
          use_sw = 1'b1;
        end else if (eff_source <= 4'h7) begin
          sl1 = eff_source[2:0] - 3'h1;
          sl2 = sl1;
          sl3 = sl1;
        end else begin
          bad = 1'b1;
        end
      end
      csk_pkg::MODE_DES2: begin
        if (eff_source == csk_pkg::SRC_SW) begin
          use_sw = 1'b1;
          sl2    = 3'h1;
        end else if (eff_source <= 4'h4) begin
          sl1 = {eff_source[1:0] - 2'h1, 1'b0};
          sl2 = {eff_source[1:0] - 2'h1, 1'b1};
          sl3 = sl1;
        end else begin
          bad = 1'b1;
        end
      end
      csk_pkg::MODE_DES3: begin
        if (eff_source <= csk_pkg::SRC_KEY1) begin
          use_sw = (eff_source == csk_pkg::SRC_SW);
          sl2    = 3'h1;
          sl3    = 3'h2;
        end else if (eff_source == 4'h2) begin
          sl1 = 3'h3;
          sl2 = 3'h4;
          sl3 = 3'h5;
        end else begin
          bad = 1'b1;
        end
      end
      default: begin
        bad = 1'b1;
      end
    endcase
    if (!use_sw && !bad) begin
      for (int q = 0; q < 3; q++) begin
        if (type_of(cfg, q == 0 ? sl1 : (q == 1 ? sl2 : sl3))
            != (s_q.mode == csk_pkg::MODE_DES3 ? csk_pkg::TYPE_DES3
                                                : csk_pkg::TYPE_DES12)) begin
          bad = 1'b1;
        end
      end
    end
    if (cfg[csk_pkg::CFG_SKEY_BIT] && eff_source == csk_pkg::SRC_KEY1) begin
      bad = 1'b1;
    end
    if (cfg[csk_pkg::CFG_SWDIS_BIT] && eff_source == csk_pkg::SRC_SW) begin
      bad = 1'b1;
    end
    key_config_fail = bad;
    case (key_pass)
      2'h0:    sel_sl = sl1;
      2'h1:    sel_sl = sl2;
      default: sel_sl = sl3;
    endcase
  end

  assign op_start_ok         = op_start_req & ~key_config_fail;
  assign program_test_mirror = cfg[csk_pkg::CFG_PROGRAMMED_BIT];
  assign key_data            = s_q.use_sw ? s_q.sw_slice : mem_rd;
  assign irq                 = |(s_q.ist & s_q.imask);

  assign s_axi_awready = ~s_q.aw_full & ~s_q.bvalid;
  assign s_axi_wready  = ~s_q.w_full & ~s_q.bvalid;
  assign s_axi_arready = ~s_q.rvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign wr_go         = s_q.aw_full & s_q.w_full & ~s_q.bvalid;

  always_comb begin
    logic [31:0] m;
    logic [2:0]  ix;
    m   = 32'h0;
    ix  = 3'h0;
    s_d = s_q;
    ev  = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_full = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    // the program strobe lasts one cycle; the store writes on it
    if (s_q.otp_cmd) begin
      s_d.otp_cmd                 = 1'b0;
      ev[csk_pkg::EV_PROG_DONE]   = 1'b1;
    end
    if (op_start_req && key_config_fail) begin
      ev[csk_pkg::EV_START_REFUSE] = 1'b1;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_d.aw_full = 1'b0;
      s_d.w_full  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = csk_pkg::RESP_OKAY;
      case (s_q.aw_addr)
        csk_pkg::OFF_CTRL: begin
          m = wmerge({26'h0, s_q.mode, s_q.src}, s_q.w_data, s_q.w_strb);
          s_d.src  = m[csk_pkg::CTRL_SRC_LSB +: 4];
          s_d.mode = m[csk_pkg::CTRL_MODE_LSB +: 2];
        end
        csk_pkg::OFF_OTP: begin
          m = wmerge({27'h0, s_q.page, 1'b0}, s_q.w_data, s_q.w_strb);
          s_d.page = m[csk_pkg::OTP_PAGE_LSB +: 4];
          if (m[csk_pkg::OTP_CMD_BIT] && !s_q.otp_cmd) begin
            if (key_config_fail
                || page_fail(cfg, m[csk_pkg::OTP_PAGE_LSB +: 4])) begin
              ev[csk_pkg::EV_PROG_REFUSE] = 1'b1;
            end else begin
              s_d.otp_cmd = 1'b1;
            end
          end
        end
        csk_pkg::OFF_DLO:  s_d.dlo = wmerge(s_q.dlo, s_q.w_data, s_q.w_strb);
        csk_pkg::OFF_DHI:  s_d.dhi = wmerge(s_q.dhi, s_q.w_data, s_q.w_strb);
        csk_pkg::OFF_IMSK: begin
          m = wmerge({29'h0, s_q.imask}, s_q.w_data, s_q.w_strb);
          s_d.imask = m[2:0];
        end
        csk_pkg::OFF_IST: begin
          s_d.ist = s_q.ist & ~(s_q.w_strb[0] ? s_q.w_data[2:0] : 3'h0);
        end
        csk_pkg::OFF_STAT, csk_pkg::OFF_CFG: begin
          s_d.bresp = csk_pkg::RESP_OKAY;
        end
        default: begin
          if (s_q.aw_addr >= csk_pkg::OFF_SWK0
              && s_q.aw_addr <= csk_pkg::OFF_SWK5
              && s_q.aw_addr[1:0] == 2'h0) begin
            ix = 3'(s_q.aw_addr[4:2]);
            s_d.swk[ix] = wmerge(s_q.swk[ix], s_q.w_data, s_q.w_strb);
          end else begin
            s_d.bresp = csk_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
    // a clear in the same cycle as an event loses to the event
    s_d.ist = s_d.ist | ev;
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = csk_pkg::RESP_OKAY;
      case (s_axi_araddr)
        csk_pkg::OFF_CTRL: s_d.rdata = {26'h0, s_q.mode, s_q.src};
        csk_pkg::OFF_STAT: s_d.rdata = {24'h0, eff_source,
                                        page_fail(cfg, s_q.page),
                                        s_q.otp_cmd, program_test_mirror,
                                        key_config_fail};
        csk_pkg::OFF_OTP:  s_d.rdata = {27'h0, s_q.page, s_q.otp_cmd};
        csk_pkg::OFF_DLO:  s_d.rdata = s_q.dlo;
        csk_pkg::OFF_DHI:  s_d.rdata = s_q.dhi;
        csk_pkg::OFF_IST:  s_d.rdata = {29'h0, s_q.ist};
        csk_pkg::OFF_IMSK: s_d.rdata = {29'h0, s_q.imask};
        csk_pkg::OFF_CFG:  s_d.rdata = cfg;
        default: begin
          // software key words are write-only and read as zero
          s_d.rdata = 32'h0;
          if (!(s_axi_araddr >= csk_pkg::OFF_SWK0
                && s_axi_araddr <= csk_pkg::OFF_SWK5
                && s_axi_araddr[1:0] == 2'h0)) begin
            s_d.rresp = csk_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
    // software key slice for the requested pass, aligned with the store
    s_d.use_sw   = use_sw;
    s_d.sw_slice = 64'h0;
    if (use_sw) begin
      s_d.sw_slice = {s_q.swk[{sel_sl[1:0], 1'b1}],
                      s_q.swk[{sel_sl[1:0], 1'b0}]};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_start_gate: assert property (
      op_start_req && key_config_fail
      |=> s_q.ist[csk_pkg::EV_START_REFUSE])
    else $error("refused start not flagged");
  chk_swdis_zero: assert property (
      cfg[csk_pkg::CFG_SWDIS_BIT] && eff_source == csk_pkg::SRC_SW
      |-> key_config_fail && !op_start_ok)
    else $error("software key used while disabled");
  chk_lock_top: assert property (
      cfg[csk_pkg::CFG_LOCK_BIT] && cfg[csk_pkg::CFG_LKSRC_LSB + 7]
      |-> eff_source == csk_pkg::SRC_RSVD)
    else $error("locked source priority wrong");
  chk_lock_low: assert property (
      cfg[csk_pkg::CFG_LOCK_BIT]
      && cfg[csk_pkg::CFG_LKSRC_LSB + 3 +: 5] == 5'h01
      |-> eff_source == 4'h4)
    else $error("locked source middle bit wrong");
  chk_unlock_src: assert property (
      !cfg[csk_pkg::CFG_LOCK_BIT] |-> eff_source == s_q.src)
    else $error("software source not used when unlocked");
  chk_mode_rsvd: assert property (
      s_q.mode == csk_pkg::MODE_RSVD |-> key_config_fail)
    else $error("reserved key mode accepted");
  chk_src_rsvd: assert property (
      eff_source == csk_pkg::SRC_RSVD |-> key_config_fail)
    else $error("reserved source accepted");
  chk_session_key: assert property (
      cfg[csk_pkg::CFG_SKEY_BIT] && eff_source == csk_pkg::SRC_KEY1
      |-> key_config_fail)
    else $error("stored key 1 used directly");
  chk_prog_refuse: assert property (
      wr_go && s_q.aw_addr == csk_pkg::OFF_OTP && s_q.w_data[0]
      && s_q.w_strb[0] && key_config_fail
      |=> !s_q.otp_cmd && s_q.ist[csk_pkg::EV_PROG_REFUSE])
    else $error("program command taken during key failure");
  chk_prog_pulse: assert property (
      s_q.otp_cmd |-> !page_fail(cfg, s_q.page)
      ##1 !s_q.otp_cmd && s_q.ist[csk_pkg::EV_PROG_DONE])
    else $error("program strobe wrong");
  chk_cfg_once: assert property (
      $past(cfg) != 32'h0 |-> (cfg & $past(cfg)) == $past(cfg))
    else $error("programmed configuration bit changed");
  chk_mirror: assert property (
      s_q.otp_cmd && s_q.page == 4'h0
      && s_q.dlo[csk_pkg::CFG_PROGRAMMED_BIT]
      |=> program_test_mirror)
    else $error("program test mirror not set");

  cov_start_ok: cover property (op_start_req && op_start_ok);
  cov_start_refused: cover property (op_start_req && key_config_fail);
  cov_program: cover property (s_q.otp_cmd ##1 cfg != $past(cfg));
  cov_des3_stored: cover property (
      s_q.mode == csk_pkg::MODE_DES3 && eff_source == 4'h2
      && !key_config_fail);

endmodule

//--- tb.sv
// tb: self-checking bench for csk_key_select, registers over AXI4-Lite.
// assumes the key store comes out of reset blank, as for a fresh part.
`timescale 1ns/1ps
module tb;
  logic        mclk, rst, awv, wv, br, arv, rr, st;
  logic        awr, wr, bv, arr, rv, ok, kf, mir, irq;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, rdat, cfg;
  logic [3:0]  ws, eff;
  logic [1:0]  bresp, rresp, resp, kp;
  logic [63:0] kd;
  logic [31:0] sw [6];
  logic [63:0] sk [1:8];
  int          bad_count, samples_checked;

  csk_key_select i_dut (.mclk(mclk), .rst(rst), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .op_start_req(st), .op_start_ok(ok),
    .key_pass(kp), .key_data(kd), .eff_source(eff),
    .key_config_fail(kf), .program_test_mirror(mir), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [63:0] e,
                     input logic [63:0] s);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // a handshake that never completes ends the run
  task automatic guard(input int n);
    if (n > 60) begin
      bad_count++;
      $display("mismatch handshake expected answer seen timeout");
      tally_and_finish();
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      guard(n);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!(br && bv));
    resp = bresp;
    br <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      guard(n);
      if (arv && arr) arv <= 1'b0;
    end while (!(rr && rv));
    rdat = rd;
    resp = rresp;
    rr <= 1'b0;
  endtask

  // mode 0 source 3 stays valid under every configuration used here
  task automatic prog(input logic [3:0] p, input logic [63:0] d);
    axw(csk_pkg::OFF_CTRL, 32'h3);
    axw(csk_pkg::OFF_DLO, d[31:0]);
    axw(csk_pkg::OFF_DHI, d[63:32]);
    axw(csk_pkg::OFF_OTP, {27'h0, p, 1'b1});
    repeat (3) @(posedge mclk);
  endtask

  function automatic logic [3:0] lead(input logic [7:0] f);
    lead = 4'h0;
    for (int i = 0; i < 7; i++) if (f[i]) lead = 4'(i + 1);
    if (f[7]) lead = 4'hF;
  endfunction

  // returns {fail, key}; key is only meaningful when fail is low
  function automatic logic [64:0] model(input logic [1:0] m,
                                        input logic [3:0] e,
                                        input int p);
    int   per, lim, q;
    logic f;
    per = (m == 2'h3) ? 3 : (m == 2'h1) ? 2 : 1;
    lim = (m == 2'h3) ? 2 : (m == 2'h1) ? 4 : 7;
    q = (m == 2'h0) ? 0 : (m == 2'h1) ? int'(p == 1) : (p > 2 ? 2 : p);
    f = (m == 2'h2) || (e > lim) || (e == 4'h0 && cfg[0]) ||
        (e == 4'h1 && cfg[19]);
    if (e == 4'h0) return {f, sw[2 * q + 1], sw[2 * q]};
    for (int j = (e - 1) * per; j < e * per && !f; j++)
      if (cfg[20 + 2 * (j / 2) +: 2] != {1'b0, m == 2'h3}) f = 1'b1;
    return f ? {f, 64'h0} : {f, sk[(e - 1) * per + q + 1]};
  endfunction

  task automatic sweep();
    logic [64:0] x;
    logic [3:0]  e;
    st <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 16; s++) begin
        axw(csk_pkg::OFF_CTRL, 32'(m * 16 + s));
        e = cfg[10] ? lead(cfg[18:11]) : 4'(s);
        for (int p = 0; p < 4; p++) begin
          kp <= 2'(p);
          @(posedge mclk);
          #1;
          x = model(2'(m), e, p);
          cmp("source", 64'(e), 64'(eff));
          cmp("fail", 64'(x[64]), 64'(kf));
          cmp("start ok", 64'(!x[64]), 64'(ok));
          if (!x[64]) cmp("key", x[63:0], kd);
          @(posedge mclk);
        end
      end
    end
    st <= 1'b0;
    $display("test sweep cfg %h done", cfg);
  endtask

  initial begin
    bad_count = 0;
    samples_checked = 0;
    {rst, awv, wv, br, arv, rr, st} = 7'h40;
    {awa, ara, wd, kp, cfg} = '0;
    ws = 4'hF;
    void'($urandom(61911));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    axr(csk_pkg::OFF_CFG);
    cmp("config", 64'h0, 64'(rdat));
    cmp("mirror", 64'h0, 64'(mir));
    axr(8'hFC);
    cmp("unmapped", 64'(csk_pkg::RESP_SLVERR), 64'(resp));
    for (int i = 0; i < 6; i++) begin
      sw[i] = $urandom;
      axw(8'(csk_pkg::OFF_SWK0 + 4 * i), sw[i]);
    end
    axw(csk_pkg::OFF_IMSK, 32'h7);
    for (int k = 1; k < 9; k++) begin
      sk[k] = {$urandom, $urandom};
      prog(4'(k), sk[k]);
    end
    cmp("irq", 64'h1, 64'(irq));
    axw(csk_pkg::OFF_IST, 32'h7);
    repeat (2) @(posedge mclk);
    cmp("irq", 64'h0, 64'(irq));
    $display("test store and interrupt done");
    sweep();
    prog(4'h0, 64'h4018_0200);
    cfg = 32'h4018_0200;
    axr(csk_pkg::OFF_STAT);
    cmp("status", 64'h32, 64'(rdat & 32'hF3));
    cmp("mirror", 64'h1, 64'(mir));
    axw(csk_pkg::OFF_IST, 32'h7);
    prog(4'h8, 64'h0);
    axr(csk_pkg::OFF_IST);
    cmp("refused lock", 64'h2, 64'(rdat));
    $display("test write lock done");
    sweep();
    prog(4'h0, 64'h0);
    prog(4'h0, 64'h1);
    cfg |= 32'h1;
    axr(csk_pkg::OFF_CFG);
    cmp("config", 64'(cfg), 64'(rdat));
    axw(csk_pkg::OFF_IST, 32'h7);
    axw(csk_pkg::OFF_CTRL, 32'h0);
    st <= 1'b1;
    #1;
    cmp("fail", 64'h1, 64'(kf));
    cmp("start ok", 64'h0, 64'(ok));
    @(posedge mclk);
    st <= 1'b0;
    axw(csk_pkg::OFF_OTP, 32'h7);
    repeat (2) @(posedge mclk);
    axr(csk_pkg::OFF_IST);
    cmp("refused", 64'h6, 64'(rdat));
    cmp("irq", 64'h1, 64'(irq));
    $display("test software key disable done");
    sweep();
    prog(4'h0, 64'h4400);
    cfg |= 32'h4400;
    sweep();
    prog(4'h0, 64'h4_0000);
    cfg |= 32'h4_0000;
    sweep();
    tally_and_finish();
  end
endmodule
